// [epsm_defines.vh]
`ifndef EPSM_DEFINES_VH
`define EPSM_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EPSM_OFS_REV        8'h00
`define EPSM_OFS_FRAC       8'h04
`define EPSM_OFS_SPEED      8'h08
`define EPSM_OFS_ZSTAT      8'h0c
`define EPSM_OFS_CTRL       8'h10
`define EPSM_OFS_PPR        8'h14
`define EPSM_OFS_IRQ_STAT   8'h18
`define EPSM_OFS_IRQ_MASK   8'h1c
// ----------------------------------------
// field positions
// ----------------------------------------
`define EPSM_CTRL_START_BIT 0
`define EPSM_ZSTAT_DONE_BIT 0
`define EPSM_IRQ_ZERO_BIT   0
`define EPSM_IRQ_SPEED_BIT  1
`define EPSM_IRQ_WRAP_BIT   2
`define EPSM_IRQ_W          3
// ----------------------------------------
// reset values
// ----------------------------------------
`define EPSM_RST_REV        16'h0000
`define EPSM_RST_FRAC       16'h0000
`define EPSM_RST_SPEED      17'h00000
`define EPSM_RST_PPR        16'h0400
`define EPSM_RST_IRQ_MASK   3'h0
// ----------------------------------------
// scaling and timing
// ----------------------------------------
`define EPSM_FRAC_SHIFT     16
`define EPSM_RPM_PER_KHZ    60000
`define EPSM_SPEED_MAX      60000
`define EPSM_CLK_HZ         40000000
`define EPSM_WIN_TIME_US    1000
`define EPSM_WIN_CYCLES     (`EPSM_WIN_TIME_US * (`EPSM_CLK_HZ / 1000000))
`define EPSM_DIV_STEPS      40
`endif

// [epsm_top.v]
// Functional notes
// [R1] reset clears revolution count and fraction
// [R2] finished zero search clears count and fraction
// [R3] full turn forward increments, reverse decrements
// [R4] fraction is unsigned 0..65535 per turn
// [R5] fraction rises forward, falls reverse
// [R6] speed from pulses counted per 1 ms
// [R7] speed value refreshed every window
// [R8] signed speed, limited to +/-60000 rpm
// [R9] raw window speed, no filtering
// [R10] zero flag 0 until search completes
// [R11] fraction = pulses*65536/ppr, carry into count
// [R12] revolution count wraps modulo 65536
`timescale 1ns/1ps
`include "epsm_defines.vh"

module epsm_top #(
  parameter WIN_CYCLES = `EPSM_WIN_CYCLES
) (
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        enc_a_in,
  input  wire        enc_b_in,
  input  wire        enc_idx_in,
  output reg         irq_out
);

  localparam ZS_IDLE   = 2'd0;
  localparam ZS_SEARCH = 2'd1;
  localparam ZS_DONE   = 2'd2;

  localparam JOB_FRAC  = 1'b0;
  localparam JOB_SPEED = 1'b1;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [2:0]  pin_meta_ff;
  reg  [2:0]  pin_sync_ff;
  reg  [2:0]  pin_last_ff;
  wire [2:0]  pin_raw;

  assign pin_raw = {enc_idx_in, enc_b_in, enc_a_in};

  // all three channels in one process, so each register has a single driver
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
      pin_last_ff <= 3'h0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  // one counted pulse per rising edge of channel a; b low means forward
  wire pulse     = pin_sync_ff[0] & ~pin_last_ff[0];
  wire fwd       = ~pin_sync_ff[1];
  wire idx_rise  = pin_sync_ff[2] & ~pin_last_ff[2];

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  reg  [15:0] ppr_ff;
  reg  [`EPSM_IRQ_W-1:0] irq_stat_ff;
  reg  [`EPSM_IRQ_W-1:0] irq_mask_ff;
  reg  [1:0]  zs_state_ff;
  reg  [15:0] rev_ff;
  reg  [15:0] frac_ff;
  reg  [16:0] speed_ff;

  wire        acc     = psel_in & penable_in;
  wire        done    = acc & pready_out;
  wire        wr_done = done & pwrite_in;
  wire        rd_done = done & ~pwrite_in;

  reg  [31:0] nxt_rdata;
  reg         nxt_err;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    if (paddr_in == `EPSM_OFS_REV) begin
      nxt_rdata = {16'h0000, rev_ff};
    end else if (paddr_in == `EPSM_OFS_FRAC) begin
      nxt_rdata = {16'h0000, frac_ff};
    end else if (paddr_in == `EPSM_OFS_SPEED) begin
      nxt_rdata = {15'h0000, speed_ff};
    end else if (paddr_in == `EPSM_OFS_ZSTAT) begin
      nxt_rdata = {31'h0000_0000, zs_state_ff == ZS_DONE};  // [R10]
    end else if (paddr_in == `EPSM_OFS_CTRL) begin
      nxt_rdata = 32'h0000_0000;
    end else if (paddr_in == `EPSM_OFS_PPR) begin
      nxt_rdata = {16'h0000, ppr_ff};
    end else if (paddr_in == `EPSM_OFS_IRQ_STAT) begin
      nxt_rdata = {29'h0000_0000, irq_stat_ff};
    end else if (paddr_in == `EPSM_OFS_IRQ_MASK) begin
      nxt_rdata = {29'h0000_0000, irq_mask_ff};
    end else begin
      nxt_err   = 1'b1;
    end
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= acc & ~pready_out;
      pslverr_out <= acc & ~pready_out & nxt_err;
      if (acc & ~pready_out & ~pwrite_in) begin
        prdata_out <= nxt_rdata;
      end else if (done) begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  wire wr_ctrl  = wr_done & (paddr_in == `EPSM_OFS_CTRL);
  wire start_zs = wr_ctrl & pwdata_in[`EPSM_CTRL_START_BIT];

  // zero pulses per turn would make the divider divide by zero, so such writes are ignored
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ppr_ff      <= `EPSM_RST_PPR;
      irq_mask_ff <= `EPSM_RST_IRQ_MASK;
    end else begin
      if (wr_done & (paddr_in == `EPSM_OFS_PPR) & (pwdata_in[15:0] != 16'h0000)) begin
        ppr_ff <= pwdata_in[15:0];
      end
      if (wr_done & (paddr_in == `EPSM_OFS_IRQ_MASK)) begin
        irq_mask_ff <= pwdata_in[`EPSM_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // zero search
  // ----------------------------------------
  reg  [1:0]  nxt_zs_state;
  wire        zs_hit = (zs_state_ff == ZS_SEARCH) & idx_rise;

  always @* begin
    nxt_zs_state = zs_state_ff;
    case (zs_state_ff)
      ZS_IDLE: begin
        if (start_zs) nxt_zs_state = ZS_SEARCH;
      end
      ZS_SEARCH: begin
        if (idx_rise) nxt_zs_state = ZS_DONE;   // [R10]
      end
      ZS_DONE: begin
        if (start_zs) nxt_zs_state = ZS_SEARCH; // [R10]
      end
      default: begin
        nxt_zs_state = ZS_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      zs_state_ff <= ZS_IDLE;
    end else begin
      zs_state_ff <= nxt_zs_state;
    end
  end

  // ----------------------------------------
  // position
  // ----------------------------------------
  reg  [15:0] turn_cnt_ff;
  wire [15:0] ppr_last = ppr_ff - 16'h0001;
  wire        wrap_fwd = pulse & fwd & (turn_cnt_ff >= ppr_last);
  wire        wrap_rev = pulse & ~fwd & (turn_cnt_ff == 16'h0000);

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      turn_cnt_ff <= 16'h0000;               // [R1]
      rev_ff      <= `EPSM_RST_REV;          // [R1]
    end else if (zs_hit) begin
      turn_cnt_ff <= 16'h0000;               // [R2]
      rev_ff      <= 16'h0000;               // [R2]
    end else if (pulse) begin
      if (fwd) begin
        if (wrap_fwd) begin
          turn_cnt_ff <= 16'h0000;           // [R11]
          rev_ff      <= rev_ff + 16'h0001;  // [R3] [R12]
        end else begin
          turn_cnt_ff <= turn_cnt_ff + 16'h0001; // [R5]
        end
      end else begin
        if (wrap_rev) begin
          turn_cnt_ff <= ppr_last;           // [R11]
          rev_ff      <= rev_ff - 16'h0001;  // [R3] [R12]
        end else begin
          turn_cnt_ff <= turn_cnt_ff - 16'h0001; // [R5]
        end
      end
    end
  end

  // ----------------------------------------
  // speed window
  // ----------------------------------------
  reg  [15:0] win_cnt_ff;
  reg  [17:0] win_pulses_ff;
  reg  [17:0] win_latch_ff;
  reg         speed_pend_ff;
  wire        win_end = (win_cnt_ff == WIN_CYCLES[15:0] - 16'h0001);
  wire [17:0] pulse_step = ~pulse ? 18'h00000 : (fwd ? 18'h00001 : 18'h3ffff);

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      win_cnt_ff    <= 16'h0000;
      win_pulses_ff <= 18'h00000;
      win_latch_ff  <= 18'h00000;
    end else if (win_end) begin
      win_cnt_ff    <= 16'h0000;             // [R6]
      win_latch_ff  <= win_pulses_ff + pulse_step; // [R6]
      win_pulses_ff <= 18'h00000;            // [R9]
    end else begin
      win_cnt_ff    <= win_cnt_ff + 16'h0001;
      win_pulses_ff <= win_pulses_ff + pulse_step;
    end
  end

  // ----------------------------------------
  // shared serial divider
  // ----------------------------------------
  // one divider serves both jobs; fraction lags pulses by 42 to 123 cycles
  reg  [39:0] div_quo_ff;
  reg  [16:0] div_rem_ff;
  reg  [5:0]  div_step_ff;
  reg         div_busy_ff;
  reg         div_job_ff;
  reg         div_neg_ff;
  reg         speed_evt_ff;
  // a pass begun before a zero hit holds a stale turn count
  reg         div_drop_ff;
  reg  [15:0] div_den_ff;

  wire        win_neg  = win_latch_ff[17];
  wire [17:0] win_mag  = win_neg ? (18'h00000 - win_latch_ff) : win_latch_ff;
  wire [39:0] spd_num  = {22'h000000, win_mag} * 40'd`EPSM_RPM_PER_KHZ;
  wire [39:0] frac_num = {8'h00, turn_cnt_ff, 16'h0000};
  wire [16:0] rem_sh   = {div_rem_ff[15:0], div_quo_ff[39]};
  wire        rem_ge   = rem_sh >= {1'b0, div_den_ff};
  wire [16:0] rem_sub  = rem_sh - {1'b0, div_den_ff};
  wire        div_last = div_busy_ff & (div_step_ff == 6'd`EPSM_DIV_STEPS - 6'd1);
  wire [39:0] quo_fin  = {div_quo_ff[38:0], rem_ge};
  wire        spd_over = quo_fin > 40'd`EPSM_SPEED_MAX;
  wire [16:0] spd_mag  = spd_over ? 17'd`EPSM_SPEED_MAX : quo_fin[16:0];

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      speed_pend_ff <= 1'b0;
    end else if (win_end) begin
      speed_pend_ff <= 1'b1;                 // [R7]
    end else if (~div_busy_ff) begin
      speed_pend_ff <= 1'b0;
    end
  end

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      div_quo_ff   <= 40'h00_0000_0000;
      div_rem_ff   <= 17'h00000;
      div_step_ff  <= 6'd0;
      div_busy_ff  <= 1'b0;
      div_job_ff   <= JOB_FRAC;
      div_neg_ff   <= 1'b0;
      div_drop_ff  <= 1'b0;
      div_den_ff   <= `EPSM_RST_PPR;
      frac_ff      <= `EPSM_RST_FRAC;        // [R1]
      speed_ff     <= `EPSM_RST_SPEED;
      speed_evt_ff <= 1'b0;
    end else begin
      speed_evt_ff <= 1'b0;
      if (zs_hit) begin
        frac_ff <= 16'h0000;                 // [R2]
        div_drop_ff <= 1'b1;                 // [R2]
      end
      if (~div_busy_ff) begin
        div_busy_ff <= 1'b1;
        div_step_ff <= 6'd0;
        div_rem_ff  <= 17'h00000;
        div_job_ff  <= speed_pend_ff ? JOB_SPEED : JOB_FRAC;
        div_neg_ff  <= win_neg;
        div_drop_ff <= zs_hit;
        div_den_ff  <= ppr_ff;
        div_quo_ff  <= speed_pend_ff ? spd_num : frac_num; // [R11]
      end else begin
        div_quo_ff  <= quo_fin;
        div_rem_ff  <= rem_ge ? rem_sub : rem_sh;
        div_step_ff <= div_step_ff + 6'd1;
        if (div_last) begin
          div_busy_ff <= 1'b0;
          if (div_job_ff == JOB_SPEED) begin
            speed_ff     <= div_neg_ff ? (17'h00000 - spd_mag) : spd_mag; // [R8] [R9]
            speed_evt_ff <= 1'b1;            // [R7]
          end else if (~zs_hit & ~div_drop_ff) begin
            frac_ff      <= quo_fin[15:0];   // [R4] [R11]
          end
        end
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [`EPSM_IRQ_W-1:0] irq_evt;
  wire                   rd_stat = rd_done & (paddr_in == `EPSM_OFS_IRQ_STAT);
  wire [`EPSM_IRQ_W-1:0] irq_keep = rd_stat ? (irq_stat_ff & ~prdata_out[`EPSM_IRQ_W-1:0])
                                            : irq_stat_ff;

  assign irq_evt[`EPSM_IRQ_ZERO_BIT]  = zs_hit;
  assign irq_evt[`EPSM_IRQ_SPEED_BIT] = speed_evt_ff;
  assign irq_evt[`EPSM_IRQ_WRAP_BIT]  = ~zs_hit & ((wrap_fwd & (rev_ff == 16'hffff)) |
                                                   (wrap_rev & (rev_ff == 16'h0000)));

  // a read clears only the bits it returned; later sets survive
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= {`EPSM_IRQ_W{1'b0}};
      irq_out     <= 1'b0;
    end else begin
      irq_stat_ff <= irq_keep | irq_evt;
      irq_out     <= |((irq_keep | irq_evt) & irq_mask_ff);
    end
  end

endmodule // epsm_top

// [epsm_assertions.sv]
`timescale 1ns/1ps
`include "epsm_defines.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module epsm_chk (
  input wire        sys_clk_in,
  input wire        sys_rst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire        enc_a_in,
  input wire        enc_b_in,
  input wire        enc_idx_in,
  input wire        irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire rd = psel_in && !pwrite_in && pready_out;
  chk_one_wait: assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_err_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error without ready or with data");
  chk_idle_data: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=> !pready_out && !irq_out)
    else $error("outputs active in reset");
  chk_frac_width: assert property (rd && paddr_in == `EPSM_OFS_FRAC |-> prdata_out[31:16] == 16'h0)
    else $error("fraction wider than 16 bits");
  chk_rev_width: assert property (rd && paddr_in == `EPSM_OFS_REV |-> prdata_out[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  chk_speed_range: assert property (rd && paddr_in == `EPSM_OFS_SPEED |-> prdata_out[31:17] == 15'h0
    && $signed(prdata_out[16:0]) <= 60000 && $signed(prdata_out[16:0]) >= -60000)
    else $error("speed out of range");
  chk_zflag_width: assert property (rd && paddr_in == `EPSM_OFS_ZSTAT |-> prdata_out[31:1] == 31'h0)
    else $error("zero flag wider than one bit");
  cov_speed: cover property (rd && paddr_in == `EPSM_OFS_SPEED && prdata_out != 32'h0);
  cov_err: cover property (pslverr_out);
  cov_irq: cover property ($rose(irq_out));
endmodule // epsm_chk

bind epsm_top epsm_chk i_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .enc_a_in(enc_a_in), .enc_b_in(enc_b_in),
  .enc_idx_in(enc_idx_in), .irq_out(irq_out));

// [epsm_enc_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// shaft encoder model
// ----------------------------------------
module epsm_enc_model (
  input  wire logic clk_in,
  output logic      enc_a_out,
  output logic      enc_b_out,
  output logic      enc_idx_out
);
  initial begin
    enc_a_out = 1'b0;
    enc_b_out = 1'b0;
    enc_idx_out = 1'b0;
  end
  // b settles before a rises, so direction is never sampled mid-change
  task pulse(input logic rev);
    @(posedge clk_in) enc_b_out <= rev;
    repeat (2) @(posedge clk_in);
    enc_a_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    enc_a_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  task index;
    @(posedge clk_in) enc_idx_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    enc_idx_out <= 1'b0;
  endtask
endmodule // epsm_enc_model

// [epsm_tb.sv]
`timescale 1ns/1ps
`include "epsm_defines.vh"
module testbench;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic        pready_out, pslverr_out, irq_out, enc_a, enc_b, enc_idx, er;
  int          n_fail = 0, n_checks = 0, i, n, m, net, rv, ppr, dir;
  logic [7:0]  rofs [7] = '{`EPSM_OFS_REV, `EPSM_OFS_FRAC, `EPSM_OFS_SPEED, `EPSM_OFS_ZSTAT,
                            `EPSM_OFS_PPR, `EPSM_OFS_IRQ_MASK, `EPSM_OFS_IRQ_STAT};
  logic [31:0] rval [7] = '{32'h0, 32'h0, 32'h0, 32'h0, {16'h0, `EPSM_RST_PPR}, 32'h0, 32'h0};
  always #12.5 sys_clk_in = ~sys_clk_in;
  epsm_top #(.WIN_CYCLES(200)) i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_idx_in(enc_idx),
    .irq_out(irq_out));
  epsm_enc_model i_enc (.clk_in(sys_clk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
    .enc_idx_out(enc_idx));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge sys_clk_in) penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      t++;
    end while (pready_out !== 1'b1 && t < 20);
    if (t >= 20) n_fail++;
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task wait_irq;
    int t;
    t = 0;
    repeat (2) @(posedge sys_clk_in);
    while (irq_out !== 1'b1 && t < 1000) begin
      @(posedge sys_clk_in);
      t++;
    end
    if (t >= 1000) n_fail++;
  endtask
  task zero_search;
    apb(1'b1, `EPSM_OFS_CTRL, 32'h1);
    rdchk("zflag busy", `EPSM_OFS_ZSTAT, 32'h0);
    i_enc.index();
    repeat (5) @(posedge sys_clk_in);
    rdchk("zflag done", `EPSM_OFS_ZSTAT, 32'h1);
    rdchk("rev zero", `EPSM_OFS_REV, 32'h0);
    rdchk("frac zero", `EPSM_OFS_FRAC, 32'h0);
  endtask
  function automatic logic [31:0] exp_speed(input int k, input int rev, input int p);
    int v;
    v = k * `EPSM_RPM_PER_KHZ / p;
    if (v > `EPSM_SPEED_MAX) v = `EPSM_SPEED_MAX;
    if (rev != 0) v = -v;
    return {15'h0, v[16:0]};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    n_fail++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h6e86af3d));
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (i = 0; i < 7; i++) rdchk("reset value", rofs[i], rval[i]);
    apb(1'b1, `EPSM_OFS_REV, 32'h1234);
    rdchk("ro count", `EPSM_OFS_REV, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    repeat (450) @(posedge sys_clk_in);
    check("masked irq", {31'h0, irq_out}, 32'h0);
    $display("test registers done");
    apb(1'b1, `EPSM_OFS_PPR, 32'h4);
    for (i = 0; i < 3; i++) begin
      n = (i == 0) ? $urandom_range(0, 9) : (i == 1) ? 4 : 0;
      m = (i == 0) ? $urandom_range(0, 12) : 1;
      zero_search;
      repeat (n) i_enc.pulse(1'b0);
      repeat (m) i_enc.pulse(1'b1);
      repeat (200) @(posedge sys_clk_in);
      net = n - m;
      rv = (net >= 0) ? net / 4 : -((3 - net) / 4);
      rdchk("rev count", `EPSM_OFS_REV, {16'h0, rv[15:0]});
      rdchk("fraction", `EPSM_OFS_FRAC, (net - 4 * rv) * 16384);
      apb(1'b0, `EPSM_OFS_IRQ_STAT, 32'h0);
      check("zero status", rd & 32'h1, 32'h1);
      if (i == 2) check("wrap status", rd & 32'h4, 32'h4);
    end
    $display("test position done");
    apb(1'b1, `EPSM_OFS_IRQ_MASK, 32'h2);
    for (i = 0; i < 4; i++) begin
      ppr = (i == 3) ? 4 : $urandom_range(100, 2000);
      n = (i == 3) ? 10 : $urandom_range(1, 10);
      dir = $urandom_range(0, 1);
      apb(1'b1, `EPSM_OFS_PPR, ppr);
      apb(1'b0, `EPSM_OFS_IRQ_STAT, 32'h0);
      wait_irq;
      apb(1'b0, `EPSM_OFS_IRQ_STAT, 32'h0);
      check("speed status", rd & 32'h2, 32'h2);
      repeat (n) i_enc.pulse(dir[0]);
      wait_irq;
      rdchk("speed", `EPSM_OFS_SPEED, exp_speed(n, dir, ppr));
      apb(1'b0, `EPSM_OFS_IRQ_STAT, 32'h0);
      wait_irq;
      rdchk("speed idle", `EPSM_OFS_SPEED, 32'h0);
    end
    $display("test speed done");
    complete_run;
  end
endmodule // testbench
